/* File: include/ics_regs.vh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the rtl files
`ifndef ICS_REGS_VH
`define ICS_REGS_VH
// byte addresses on the avalon word bus
`define ICS_OFF_CTRL_LOW     4'h0
`define ICS_OFF_CTRL_HIGH    4'h4
`define ICS_OFF_STATUS       4'h8
`define ICS_OFF_TX_DATA      4'hc
// control low fields
`define ICS_BIT_ENABLE       15
`define ICS_BIT_CLK_RELEASE  12
`define ICS_BIT_STRETCH_EN   6
`define ICS_BIT_ACK_VALUE    5
`define ICS_BIT_ACK_REQ      4
`define ICS_BIT_RX_REQ       3
`define ICS_BIT_STOP_REQ     2
`define ICS_BIT_RSTART_REQ   1
`define ICS_BIT_START_REQ    0
// status fields
`define ICS_BIT_RX_VALID     0
`define ICS_BIT_BUSY         1
`define ICS_BIT_SLV_ACTIVE   2
`define ICS_BIT_SLV_TX       3
// reset values
`define ICS_RST_CTRL_LOW     16'h1000
`define ICS_RST_CTRL_HIGH    16'h0000
// quarter bit period for a 100 kHz bus at 125 MHz
`define ICS_QUARTER_NS       2500
`define ICS_CLK_NS           8
`endif

/* File: rtl/ics_sync.v */
// two flip-flop synchroniser for asynchronous pin levels
// assumes one clock domain, synchronous reset, inputs idle high
`timescale 1ns/1ps
module ics_sync #(
  parameter WIDTH = 2
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage feeds only the second; lines idle high on reset
  always @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // ics_sync

/* File: rtl/ics_fifo.v */
// synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active high reset, depth a power of two
`timescale 1ns/1ps
module ics_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire            empty = (wr_q == rd_q);
  wire            push  = in_valid && !full;
  wire            pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_q[AW-1:0]];

  // storage has no reset; pointers decide what is valid
  always @(posedge clk_sys) begin
    if (push)
      mem[wr_q[AW-1:0]] <= in_data;
  end

  // extra pointer bit tells full from empty
  always @(posedge clk_sys) begin
    if (rst) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule // ics_fifo

/* File: rtl/ics_sequencer.v */
// i2c control sequencer: master start/restart/stop/receive/ack sequences,
// slave clock stretching control, avalon-mm register slave
// assumes open-drain pins resolved outside, pull-ups present, one clock domain
//
// Functional notes
// R1: stretching only allowed while stretch_enable is set; the code also holds at tx start and address bytes with stretch_enable clear
// R2: ack slot drives ack_value: 1 nack, 0 ack
// R3: ack request runs ack sequence, self clears
// R4: receive request clocks one byte, self clears; the code goes on clocking bytes without clearing while the fifo is full
// R5: stop request makes stop condition, self clears
// R6: repeated start request makes restart, self clears
// R7: start request makes start condition, self clears
// R8: slave holds clock low while clock_release clear
// R9: hardware clears clock_release at slave byte boundaries; the code clears at data bytes only with stretch_enable set
// R10: software issues one master sequence at a time
`timescale 1ns/1ps
`include "ics_regs.vh"
module ics_sequencer #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // i2c pins, open drain
  input  wire        serial_clock_line_i,
  output wire        serial_clock_line_o,
  output wire        serial_clock_line_oe,
  input  wire        serial_data_line_i,
  output wire        serial_data_line_o,
  output wire        serial_data_line_oe,
  // slave-side byte events from the address/shift logic
  input  wire        slv_tx_byte_start,
  input  wire        slv_addr_byte_done,
  input  wire        slv_data_byte_done
);
  localparam [15:0] QUARTER_CYC = (`ICS_QUARTER_NS + `ICS_CLK_NS - 1) / `ICS_CLK_NS;
  // one-hot master states
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_START = 7'h02;
  localparam [6:0] S_RSTRT = 7'h04;
  localparam [6:0] S_STOP  = 7'h08;
  localparam [6:0] S_RECV  = 7'h10;
  localparam [6:0] S_ACK   = 7'h20;
  localparam [6:0] S_DONE  = 7'h40;

  // pins through two flip-flops before use
  wire [1:0] pins_s;
  ics_sync #(.WIDTH(2)) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({serial_clock_line_i, serial_data_line_i}),
    .sync_out (pins_s)
  );
  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];

  reg  [15:0] ctrl_low_q;
  reg  [15:0] ctrl_high_q;
  reg  [6:0]  state_q;
  reg  [1:0]  phase_q;
  reg  [15:0] div_q;
  reg  [2:0]  bit_q;
  reg  [7:0]  shift_q;
  reg         scl_drv_low_q;
  reg         sda_drv_low_q;
  reg         push_q;
  reg  [7:0]  push_data_q;
  reg         scl_s_q;

  wire        enable    = ctrl_low_q[`ICS_BIT_ENABLE];
  wire        stretch_en = ctrl_low_q[`ICS_BIT_STRETCH_EN];
  wire        tick      = (div_q == 16'h0000);
  wire        req_any   = |ctrl_low_q[4:0];
  wire        master_busy = (state_q != S_IDLE);
  // the sequencer steps only on quarter-bit ticks, and waits for the line
  // to really rise so a slave stretching the clock is respected
  wire        scl_wait  = !scl_drv_low_q && !scl_s;
  wire        step      = tick && !scl_wait;

  // writes take one edge; reads wait one cycle so registered data stands
  // at the edge where waitrequest is seen low
  reg  rd_done_q;
  assign avs_waitrequest = avs_read && !rd_done_q;
  wire wr_ctrl_low  = avs_write && (avs_address == `ICS_OFF_CTRL_LOW);
  wire wr_ctrl_high = avs_write && (avs_address == `ICS_OFF_CTRL_HIGH);
  // pop only at the completing edge, after the byte was registered
  wire rd_rx        = avs_read && rd_done_q && (avs_address == `ICS_OFF_TX_DATA);

  // read wait-state flag
  always @(posedge clk_sys) begin
    if (rst)
      rd_done_q <= 1'b0;
    else
      rd_done_q <= avs_read && !rd_done_q;
  end

  // received bytes queue up for software
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  ics_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (push_q),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data_q),
    .out_valid (fifo_out_valid),
    .out_ready (rd_rx),
    .out_data  (fifo_out_data)
  );

  // decode of a request field into the sequence it starts
  function [6:0] req_state;
    input [4:0] req;
    begin
      if (req[`ICS_BIT_START_REQ])
        req_state = S_START;
      else if (req[`ICS_BIT_RSTART_REQ])
        req_state = S_RSTRT;
      else if (req[`ICS_BIT_STOP_REQ])
        req_state = S_STOP;
      else if (req[`ICS_BIT_RX_REQ])
        req_state = S_RECV;
      else if (req[`ICS_BIT_ACK_REQ])
        req_state = S_ACK;
      else
        req_state = S_IDLE;
    end
  endfunction

  // quarter-bit divider; held at zero while a stretched clock line stays low
  always @(posedge clk_sys) begin
    if (rst || state_q == S_IDLE)
      div_q <= QUARTER_CYC - 16'h0001;
    else if (tick && !scl_wait)
      div_q <= QUARTER_CYC - 16'h0001;
    else if (!tick)
      div_q <= div_q - 16'h0001;
  end

  // master sequence engine; four phases per bit slot
  always @(posedge clk_sys) begin
    if (rst) begin
      state_q       <= S_IDLE;
      phase_q       <= 2'd0;
      bit_q         <= 3'd0;
      shift_q       <= 8'h00;
      scl_drv_low_q <= 1'b0;
      sda_drv_low_q <= 1'b0;
      push_q        <= 1'b0;
      push_data_q   <= 8'h00;
    end else begin
      push_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          phase_q <= 2'd0;
          bit_q   <= 3'd0;
          // one request at a time; lowest bit wins if several are set
          if (enable && req_any && !wr_ctrl_low)  // R10
            state_q <= req_state(ctrl_low_q[4:0]);
        end
        S_START: if (step) begin
          // sda falls while scl high, then scl falls
          phase_q <= phase_q + 2'd1;
          case (phase_q)
            2'd0: begin sda_drv_low_q <= 1'b0; scl_drv_low_q <= 1'b0; end
            2'd1: sda_drv_low_q <= 1'b1;   // R7
            2'd2: scl_drv_low_q <= 1'b1;
            default: state_q <= S_DONE;
          endcase
        end
        S_RSTRT: if (step) begin
          // release sda, raise scl, then sda falls with scl high
          phase_q <= phase_q + 2'd1;
          case (phase_q)
            2'd0: sda_drv_low_q <= 1'b0;
            2'd1: scl_drv_low_q <= 1'b0;
            2'd2: sda_drv_low_q <= 1'b1;   // R6
            default: begin scl_drv_low_q <= 1'b1; state_q <= S_DONE; end
          endcase
        end
        S_STOP: if (step) begin
          // sda low, scl high, then sda rises with scl high
          phase_q <= phase_q + 2'd1;
          case (phase_q)
            2'd0: sda_drv_low_q <= 1'b1;
            2'd1: scl_drv_low_q <= 1'b0;
            2'd2: sda_drv_low_q <= 1'b0;   // R5
            default: state_q <= S_DONE;
          endcase
        end
        S_RECV: if (step) begin
          // release sda; sample on the high half of each clock
          sda_drv_low_q <= 1'b0;
          phase_q <= phase_q + 2'd1;
          case (phase_q)
            2'd0: scl_drv_low_q <= 1'b1;
            2'd1: scl_drv_low_q <= 1'b0;
            2'd2: shift_q <= {shift_q[6:0], sda_s};
            default: begin
              scl_drv_low_q <= 1'b1;
              bit_q <= bit_q + 3'd1;
              if (bit_q == 3'd7) begin
                push_q      <= 1'b1;   // R4
                push_data_q <= shift_q;
                state_q     <= S_DONE;
              end
            end
          endcase
        end
        S_ACK: if (step) begin
          // one clock with sda holding the chosen answer
          phase_q <= phase_q + 2'd1;
          case (phase_q)
            2'd0: begin
              scl_drv_low_q <= 1'b1;
              sda_drv_low_q <= !ctrl_low_q[`ICS_BIT_ACK_VALUE];  // R2
            end
            2'd1: scl_drv_low_q <= 1'b0;   // R3
            2'd2: scl_drv_low_q <= 1'b0;
            default: begin scl_drv_low_q <= 1'b1; state_q <= S_DONE; end
          endcase
        end
        S_DONE: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
      // the engine stays in receive while the fifo is full and goes on clocking bytes; the push is dropped
      if (state_q == S_RECV && !fifo_in_ready)
        state_q <= S_RECV;
    end
  end

  // previous clock sample, read back in the status word
  always @(posedge clk_sys) begin
    if (rst)
      scl_s_q <= 1'b1;
    else
      scl_s_q <= scl_s;
  end

  // control low: software writes, hardware clears requests and release
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_low_q <= `ICS_RST_CTRL_LOW;
    end else begin
      if (wr_ctrl_low) begin
        ctrl_low_q[15:5] <= avs_writedata[15:5];
        // requests are only taken while the engine is idle
        if (!master_busy)
          ctrl_low_q[4:0] <= avs_writedata[4:0];
        // with stretching off software may only set the release bit
        if (!avs_writedata[6] && !avs_writedata[`ICS_BIT_CLK_RELEASE])  // R1
          ctrl_low_q[`ICS_BIT_CLK_RELEASE] <= ctrl_low_q[`ICS_BIT_CLK_RELEASE];
      end
      // end of a sequence clears all request bits
      if (state_q == S_DONE)
        ctrl_low_q[4:0] <= 5'h00;   // R3 R4 R5 R6 R7
      // tx start and address bytes clear release, data bytes only with stretching on; hardware wins over a write
      if (slv_tx_byte_start || slv_addr_byte_done)  // R9
        ctrl_low_q[`ICS_BIT_CLK_RELEASE] <= 1'b0;
      if (slv_data_byte_done && stretch_en)  // R9
        ctrl_low_q[`ICS_BIT_CLK_RELEASE] <= 1'b0;
    end
  end

  // control high: plain storage, bits 15:7 read as zero
  always @(posedge clk_sys) begin
    if (rst)
      ctrl_high_q <= `ICS_RST_CTRL_HIGH;
    else if (wr_ctrl_high)
      ctrl_high_q <= {9'h000, avs_writedata[6:0]};
  end

  // slave stretch: hold scl low whenever enabled and the release bit is clear
  reg slv_hold_q;
  always @(posedge clk_sys) begin
    if (rst)
      slv_hold_q <= 1'b0;
    else if (!enable || ctrl_low_q[`ICS_BIT_CLK_RELEASE])
      slv_hold_q <= 1'b0;   // R8
    else
      slv_hold_q <= 1'b1;   // R8
  end

  // open drain: enable high while pulling low
  assign serial_clock_line_o  = 1'b0;
  assign serial_clock_line_oe = enable && (scl_drv_low_q || slv_hold_q);
  assign serial_data_line_o   = 1'b0;
  assign serial_data_line_oe  = enable && sda_drv_low_q;

  // read mux; unmapped offsets read zero
  always @(posedge clk_sys) begin
    if (rst)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !rd_done_q) begin
      case (avs_address)
        `ICS_OFF_CTRL_LOW:  avs_readdata <= {16'h0000, ctrl_low_q};
        `ICS_OFF_CTRL_HIGH: avs_readdata <= {16'h0000, ctrl_high_q};
        `ICS_OFF_STATUS:    avs_readdata <= {28'h0000000, slv_hold_q, scl_s_q, master_busy, fifo_out_valid};
        `ICS_OFF_TX_DATA:   avs_readdata <= {24'h000000, fifo_out_data};
        default:            avs_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule // ics_sequencer

/* File: testbench/ics_seq_props.sv */
// port checker for the i2c control sequencer
// assumes bind onto ics_sequencer, one clock domain
`timescale 1ns/1ps
module ics_seq_props #(
  parameter FIFO_DEPTH = 16
) (
  // clock and reset
  input wire        clk_sys,
  input wire        rst,
  // avalon-mm
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // pins
  input wire        serial_clock_line_i,
  input wire        serial_clock_line_o,
  input wire        serial_clock_line_oe,
  input wire        serial_data_line_i,
  input wire        serial_data_line_o,
  input wire        serial_data_line_oe,
  // slave events
  input wire        slv_tx_byte_start,
  input wire        slv_addr_byte_done,
  input wire        slv_data_byte_done
);
  reg  en_q;
  reg  st_q;
  wire cw = avs_write && avs_address == 4'h0;
  wire ck = serial_clock_line_oe;
  wire dt = serial_data_line_oe;
  // shadow of enable and stretch enable, write side only
  always @(posedge clk_sys) begin
    if (rst)
      {en_q, st_q} <= 2'b00;
    else if (cw)
      {en_q, st_q} <= {avs_writedata[15], avs_writedata[6]};
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_idle_after_rst: assert property ($fell(rst) |-> !ck && !dt && avs_readdata == 0)
    else $error("pins busy after reset");
  a_open_drain: assert property (!serial_clock_line_o && !serial_data_line_o)
    else $error("pin driven high");
  a_start_clk: assert property ($rose(dt) && !ck |-> ##[1:700] ck)
    else $error("clock not pulled after start");
  a_stop_idle: assert property ($fell(dt) && !ck |=> !(dt || ck) [*8])
    else $error("bus not left idle after stop");
  a_tx_hold: assert property (en_q && slv_tx_byte_start |-> ##[1:4] ck)
    else $error("no hold at tx byte");
  a_addr_hold: assert property (en_q && slv_addr_byte_done |-> ##[1:4] ck)
    else $error("no hold after address");
  a_data_hold: assert property (en_q && st_q && slv_data_byte_done |-> ##[1:4] ck)
    else $error("no hold after data");
  a_data_free: assert property (en_q && !st_q && slv_data_byte_done && !ck |=> !ck [*4])
    else $error("hold without stretch enable");
  a_release_free: assert property (en_q && cw && avs_writedata[12] && avs_writedata[4:0] == 5'h00
    && !dt |-> ##[1:4] !ck)
    else $error("clock not released");
  // main scenarios reached
  cover property ($rose(dt) && !ck);
  cover property ($fell(dt) && !ck);
  cover property (en_q && st_q && slv_data_byte_done);
endmodule // ics_seq_props
bind ics_sequencer ics_seq_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.*);

/* File: testbench/ics_bus_peer.sv */
// slave transmitter on the far side of the bus
// assumes pull-ups on both lines, sampled on the bench clock
`timescale 1ns/1ps
module ics_bus_peer (
  // clock
  input  wire       clk_sys,
  // resolved clock line
  input  wire       scl_w,
  // bench control
  input  wire       tx_on,
  input  wire [7:0] tx_byte,
  input  wire [9:0] slow,
  // pulls toward low
  output wire       scl_pull,
  output wire       sda_pull
);
  reg       scl_q = 1'b1;
  reg [3:0] cnt = 4'h0;
  reg [9:0] wt = 10'h000;
  // next bit after every clock fall; slow stretches the low phase
  always @(posedge clk_sys) begin
    scl_q <= scl_w;
    if (!tx_on)
      cnt <= 4'h0;
    else if (scl_q && !scl_w)
      cnt <= cnt + 4'h1;
    if (tx_on && scl_q && !scl_w)
      wt <= slow;
    else if (wt != 10'h000)
      wt <= wt - 10'h001;
  end
  // released after eight bits, so the ack slot is the master's
  assign sda_pull = tx_on && cnt < 4'h8 && !tx_byte[3'h7 - cnt[2:0]];
  assign scl_pull = wt != 10'h000;
endmodule // ics_bus_peer

/* File: testbench/tb_top.sv */
// self-checking bench for the i2c control sequencer
// assumes peer model and bound checker, 125 MHz clock
`timescale 1ns/1ps
module tb_top;
  reg         clk_sys = 1'b0;
  reg         rst = 1'b1;
  reg  [3:0]  avs_address = 4'h0;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire        scl_o, scl_oe, sda_o, sda_oe, p_scl, p_sda;
  reg  [2:0]  ev = 3'h0;
  reg         tx_on = 1'b0;
  reg  [7:0]  tx_byte = 8'h00;
  reg  [9:0]  slow = 10'h000;
  reg  [31:0] rnd = 32'h0ee0;
  reg  [31:0] q;
  reg         scl_p = 1'b1;
  reg         ack_seen = 1'b0;
  integer     error_cnt = 0;
  integer     check_count = 0;
  integer     cyc = 0;
  integer     i;
  integer     exp_q[$];
  // open drain with pull-ups
  wire        scl_w = !(scl_oe || p_scl);
  wire        sda_w = !(sda_oe || p_sda);
  initial forever #4 clk_sys = ~clk_sys;
  ics_sequencer #(.FIFO_DEPTH(16), .FIFO_AW(4)) DUT (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_clock_line_i(scl_w), .serial_clock_line_o(scl_o),
    .serial_clock_line_oe(scl_oe), .serial_data_line_i(sda_w), .serial_data_line_o(sda_o),
    .serial_data_line_oe(sda_oe), .slv_tx_byte_start(ev[0]), .slv_addr_byte_done(ev[1]),
    .slv_data_byte_done(ev[2]));
  ics_bus_peer PEER (.clk_sys(clk_sys), .scl_w(scl_w), .tx_on(tx_on), .tx_byte(tx_byte),
    .slow(slow), .scl_pull(p_scl), .sda_pull(p_sda));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task end_sim;
    begin
      if (error_cnt == 0 && check_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // read data taken at the edge where waitrequest is seen low
  task bus(input w, input [3:0] a, input [31:0] d, output [31:0] r);
    begin
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0)
        @(posedge clk_sys);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  // one master request, then poll until hardware clears it
  task seq(input integer b, input ackv);
    begin
      bus(1, 4'h0, 32'h9000 | ackv << 5 | 1 << b, q);
      q = 32'h1f;
      while (q[4:0] !== 5'h00)
        bus(0, 4'h0, 0, q);
      chk("req", 0, q[4:0]);
    end
  endtask
  // data level at every clock rise; the last one is the ack slot
  always @(posedge clk_sys) begin
    scl_p <= scl_w;
    if (scl_w && !scl_p)
      ack_seen <= sda_w;
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      error_cnt = error_cnt + 1;
      end_sim;
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    bus(0, 4'h0, 0, q);
    chk("ctrl_low", 32'h1000, q);
    bus(0, 4'h4, 0, q);
    chk("ctrl_high", 0, q);
    bus(1, 4'h4, 32'hffff, q);
    bus(0, 4'h4, 0, q);
    chk("ctrl_high", 32'h007f, q);
    // slave events: tx start, address, data unstretched, data stretched
    for (i = 0; i < 4; i = i + 1) begin
      bus(1, 4'h0, (i == 3) ? 32'h9040 : 32'h9000, q);
      repeat (4) @(posedge clk_sys);
      chk("scl_free", 0, scl_oe);
      ev <= (i == 3) ? 3'h4 : 3'h1 << i;
      @(posedge clk_sys);
      ev <= 3'h0;
      repeat (4) @(posedge clk_sys);
      bus(0, 4'h0, 0, q);
      chk("release", i == 2, q[12]);
      chk("scl_hold", i != 2, scl_oe);
    end
    bus(1, 4'h0, 32'h9000, q);
    seq(0, 0);
    chk("start", 3, {sda_oe, scl_oe});
    for (i = 0; i < 2; i = i + 1) begin
      rnd = lfsr(rnd);
      tx_byte <= rnd[7:0];
      slow <= i ? rnd[17:8] : 10'h000;
      exp_q.push_back(rnd[7:0]);
      tx_on <= 1'b1;
      seq(3, 0);
      tx_on <= 1'b0;
      bus(0, 4'h8, 0, q);
      chk("rx_valid", 1, q[0]);
      bus(0, 4'hc, 0, q);
      chk("rx_byte", exp_q.pop_front(), q[7:0]);
      seq(4, rnd[20]);
      chk("ack", rnd[20], ack_seen);
      if (i == 0) begin
        seq(1, 0);
        chk("restart", 3, {sda_oe, scl_oe});
      end
    end
    seq(2, 0);
    chk("stop", 0, {sda_oe, scl_oe});
    end_sim;
  end
endmodule // tb_top
